// *** logic/crr_pkg.sv ***
/*
  Shared constants and carrier types for the cable-reflectometry register bank.
  Assumes a 32-bit AXI4-Lite slave; each 16-bit register sits in the low half of
  one aligned word at byte address four times its index.
*/
package crr_pkg;

  localparam int unsigned CRR_ADDR_W  = 16;
  localparam int unsigned CRR_DATA_W  = 32;
  localparam int unsigned CRR_REG_W   = 16;
  localparam int unsigned CRR_LOC_W   = 7;

  // register indices; byte address is index * 4
  localparam logic [13:0] CRR_IDX_PROBE_TIMING = 14'h0300;
  localparam logic [13:0] CRR_IDX_TAP_WINDOW   = 14'h0301;
  localparam logic [13:0] CRR_IDX_PROBE_DUR    = 14'h0302;
  localparam logic [13:0] CRR_IDX_THR_OFFSET   = 14'h0303;
  localparam logic [13:0] CRR_IDX_THR_SLOPE    = 14'h0304;
  localparam logic [13:0] CRR_IDX_PEAK_RESULT  = 14'h0305;

  // writable-bit masks
  localparam logic [15:0] CRR_MASK_PROBE_TIMING = 16'h1fff;
  localparam logic [15:0] CRR_MASK_TAP_WINDOW   = 16'h7f7f;
  localparam logic [15:0] CRR_MASK_PROBE_DUR    = 16'hffff;
  localparam logic [15:0] CRR_MASK_THR_OFFSET   = 16'h7fff;
  localparam logic [15:0] CRR_MASK_THR_SLOPE    = 16'h00ff;

  // reset values
  localparam logic [15:0] CRR_RST_PROBE_TIMING = 16'h0545;
  localparam logic [15:0] CRR_RST_TAP_WINDOW   = 16'h2404;
  localparam logic [15:0] CRR_RST_PROBE_DUR    = 16'h3e80;
  localparam logic [15:0] CRR_RST_THR_OFFSET   = 16'h053e;
  localparam logic [15:0] CRR_RST_THR_SLOPE    = 16'h000a;
  localparam logic [6:0]  CRR_RST_PEAK_LOC     = 7'h00;

  // field positions
  localparam int unsigned CRR_POS_TX_LEVEL   = 12;
  localparam int unsigned CRR_POS_SHADOW2    = 8;
  localparam int unsigned CRR_POS_SHADOW1    = 4;
  localparam int unsigned CRR_POS_POST_QUIET = 2;
  localparam int unsigned CRR_POS_PRE_QUIET  = 0;
  localparam int unsigned CRR_POS_TAP_END    = 8;
  localparam int unsigned CRR_POS_TAP_START  = 0;
  localparam int unsigned CRR_POS_THR_TAPOFS = 8;
  localparam int unsigned CRR_POS_THR_CONST  = 0;
  localparam int unsigned CRR_POS_PEAK1      = 8;
  localparam int unsigned CRR_POS_PEAK0      = 0;

  localparam logic [1:0] CRR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CRR_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic        tx_level_high;   // 0: 1 V probe, 1: 2.4 V probe
    logic [3:0]  shadow_seg2;
    logic [3:0]  shadow_seg1;
    logic [1:0]  post_quiet;
    logic [1:0]  pre_quiet;
    logic [6:0]  tap_end;
    logic [6:0]  tap_start;
    logic [15:0] probe_dur_us;
    logic [6:0]  thr_tap_ofs;
    logic [7:0]  thr_const;
    logic [7:0]  thr_slope_x16;
  } crr_cfg_t;

  typedef struct packed {
    logic [6:0] peak1;
    logic [6:0] peak0;
  } crr_peaks_t;

endpackage

// *** logic/crr_peak_hold.sv ***
/*
  Holds the located reflection peaks between measurements.
  Assumes the engine runs on aclk and strobes done for one cycle with valid peaks.
*/
`timescale 1ns/1ps
`default_nettype none

module crr_peak_hold (
  input  wire logic              aclk,     // system clock
  input  wire logic              aresetn,  // synchronous reset, active low
  input  wire logic              done,     // measurement complete strobe
  input  wire crr_pkg::crr_peaks_t peaks_in, // peaks from engine
  output var  crr_pkg::crr_peaks_t peaks_reg // held peaks
);
  import crr_pkg::*;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peaks_reg <= '{peak1: CRR_RST_PEAK_LOC, peak0: CRR_RST_PEAK_LOC};
    end else if (done) begin
      peaks_reg <= peaks_in;
    end
  end

endmodule

`default_nettype wire

// *** logic/crr_regs.sv ***
/*
  Cable-reflectometry configuration and result register bank, AXI4-Lite slave.
  Assumes the probe engine sits on aclk; it reads the configuration outputs and
  strobes meas_done with the two peak locations when a measurement finishes.
*/
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module crr_regs (
  input  wire logic                         aclk,      // system clock
  input  wire logic                         aresetn,   // synchronous reset, active low
  input  wire logic [crr_pkg::CRR_ADDR_W-1:0] s_awaddr,  // write address
  input  wire logic                         s_awvalid, // write address valid
  output var  logic                         s_awready, // write address ready
  input  wire logic [crr_pkg::CRR_DATA_W-1:0] s_wdata,   // write data
  input  wire logic [3:0]                   s_wstrb,   // write byte strobes
  input  wire logic                         s_wvalid,  // write data valid
  output var  logic                         s_wready,  // write data ready
  output var  logic [1:0]                   s_bresp,   // write response
  output var  logic                         s_bvalid,  // write response valid
  input  wire logic                         s_bready,  // write response ready
  input  wire logic [crr_pkg::CRR_ADDR_W-1:0] s_araddr,  // read address
  input  wire logic                         s_arvalid, // read address valid
  output var  logic                         s_arready, // read address ready
  output var  logic [crr_pkg::CRR_DATA_W-1:0] s_rdata,   // read data
  output var  logic [1:0]                   s_rresp,   // read response
  output var  logic                         s_rvalid,  // read data valid
  input  wire logic                         s_rready,  // read data ready
  input  wire logic                         meas_done, // engine finished, one cycle
  input  wire crr_pkg::crr_peaks_t          meas_peaks, // peaks with meas_done
  output var  crr_pkg::crr_cfg_t            cfg        // configuration to engine
);
  import crr_pkg::*;

  logic [15:0]            timing_reg;
  logic [15:0]            tapwin_reg;
  logic [15:0]            dur_reg;
  logic [15:0]            throfs_reg;
  logic [15:0]            slope_reg;
  crr_peaks_t             peaks_reg;
  logic [CRR_ADDR_W-1:0]  awaddr_reg;
  logic [CRR_DATA_W-1:0]  wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   aw_have_reg;
  logic                   w_have_reg;
  logic                   awready_reg;
  logic                   wready_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   arready_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [CRR_DATA_W-1:0]  rdata_reg;
  logic                   wr_go;
  logic [15:0]            lane_mask;

  // index 0..5 for mapped registers, 7 for unmapped
  function automatic logic [2:0] reg_sel(input logic [CRR_ADDR_W-1:0] addr);
    logic [13:0] idx;
    idx = addr[CRR_ADDR_W-1:2];
    unique case (idx)
      CRR_IDX_PROBE_TIMING: reg_sel = 3'h0;
      CRR_IDX_TAP_WINDOW:   reg_sel = 3'h1;
      CRR_IDX_PROBE_DUR:    reg_sel = 3'h2;
      CRR_IDX_THR_OFFSET:   reg_sel = 3'h3;
      CRR_IDX_THR_SLOPE:    reg_sel = 3'h4;
      CRR_IDX_PEAK_RESULT:  reg_sel = 3'h5;
      default:              reg_sel = 3'h7;
    endcase
  endfunction

  // merge write data into a register, masked by field bits and byte lanes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] fmask,
                                        input logic [15:0] lmask);
    logic [15:0] m;
    m = fmask & lmask;
    merge = (old & ~m) | (wd & m);
  endfunction

  assign wr_go     = aw_have_reg && w_have_reg && !bvalid_reg;
  assign lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // write address channel; slot stays closed until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_awvalid && awready_reg) begin
      aw_have_reg <= 1'b1;
      awready_reg <= 1'b0;
      awaddr_reg  <= s_awaddr;
    end else if (wr_go) begin
      aw_have_reg <= 1'b0;
    end else if (!aw_have_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  // write data channel, independent of the address so either may lead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_wvalid && wready_reg) begin
      w_have_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg  <= s_wdata;
      wstrb_reg  <= s_wstrb;
    end else if (wr_go) begin
      w_have_reg <= 1'b0;
    end else if (!w_have_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // configuration storage; writes to the result word are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_reg <= CRR_RST_PROBE_TIMING;
      tapwin_reg <= CRR_RST_TAP_WINDOW;
      dur_reg    <= CRR_RST_PROBE_DUR;
      throfs_reg <= CRR_RST_THR_OFFSET;
      slope_reg  <= CRR_RST_THR_SLOPE;
    end else if (wr_go) begin
      unique case (reg_sel(awaddr_reg))
        3'h0: timing_reg <= merge(timing_reg, wdata_reg[15:0], CRR_MASK_PROBE_TIMING,
                                  lane_mask);
        3'h1: tapwin_reg <= merge(tapwin_reg, wdata_reg[15:0], CRR_MASK_TAP_WINDOW,
                                  lane_mask);
        3'h2: dur_reg    <= merge(dur_reg, wdata_reg[15:0], CRR_MASK_PROBE_DUR,
                                  lane_mask);
        3'h3: throfs_reg <= merge(throfs_reg, wdata_reg[15:0], CRR_MASK_THR_OFFSET,
                                  lane_mask);
        3'h4: slope_reg  <= merge(slope_reg, wdata_reg[15:0], CRR_MASK_THR_SLOPE,
                                  lane_mask);
        default: ;
      endcase
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= CRR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (reg_sel(awaddr_reg) == 3'h7) ? CRR_RESP_DECERR : CRR_RESP_OKAY;
    end else if (bvalid_reg && s_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel: one read at a time, data registered the cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= CRR_RESP_OKAY;
      rdata_reg   <= '0;
    end else if (s_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= CRR_RESP_OKAY;
      unique case (reg_sel(s_araddr))
        3'h0: rdata_reg <= {16'h0000, timing_reg & CRR_MASK_PROBE_TIMING};
        3'h1: rdata_reg <= {16'h0000, tapwin_reg & CRR_MASK_TAP_WINDOW};
        3'h2: rdata_reg <= {16'h0000, dur_reg};
        3'h3: rdata_reg <= {16'h0000, throfs_reg & CRR_MASK_THR_OFFSET};
        3'h4: rdata_reg <= {16'h0000, slope_reg & CRR_MASK_THR_SLOPE};
        3'h5: rdata_reg <= {16'h0000, 1'b0, peaks_reg.peak1, 1'b0, peaks_reg.peak0};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= CRR_RESP_DECERR;
        end
      endcase
    end else if (rvalid_reg && s_rready) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  crr_peak_hold u_peak_hold (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .done      (meas_done),
    .peaks_in  (meas_peaks),
    .peaks_reg (peaks_reg)
  );

  assign s_awready = awready_reg;
  assign s_wready  = wready_reg;
  assign s_bvalid  = bvalid_reg;
  assign s_bresp   = bresp_reg;
  assign s_arready = arready_reg;
  assign s_rvalid  = rvalid_reg;
  assign s_rresp   = rresp_reg;
  assign s_rdata   = rdata_reg;

  // one process drives the whole struct, so cfg has a single driver
  always_comb begin
    cfg.tx_level_high = timing_reg[CRR_POS_TX_LEVEL];
    cfg.shadow_seg2   = timing_reg[CRR_POS_SHADOW2 +: 4];
    cfg.shadow_seg1   = timing_reg[CRR_POS_SHADOW1 +: 4];
    cfg.post_quiet    = timing_reg[CRR_POS_POST_QUIET +: 2];
    cfg.pre_quiet     = timing_reg[CRR_POS_PRE_QUIET +: 2];
    cfg.tap_end       = tapwin_reg[CRR_POS_TAP_END +: 7];
    cfg.tap_start     = tapwin_reg[CRR_POS_TAP_START +: 7];
    cfg.probe_dur_us  = dur_reg;
    cfg.thr_tap_ofs   = throfs_reg[CRR_POS_THR_TAPOFS +: 7];
    cfg.thr_const     = throfs_reg[CRR_POS_THR_CONST +: 8];
    cfg.thr_slope_x16 = slope_reg[7:0];
  end

endmodule

`default_nettype wire

// *** bench/crr_regs_checker.sv ***
/*
  Port-level checks for the reflectometry register bank.
  Assumes one clock aclk and a synchronous, active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module crr_regs_checker (
  input wire logic                         aclk,      // clock
  input wire logic                         aresetn,   // reset, active low
  input wire logic                         s_awvalid, // aw valid
  input wire logic                         s_awready, // aw ready
  input wire logic                         s_wvalid,  // w valid
  input wire logic                         s_wready,  // w ready
  input wire logic                         s_arvalid, // ar valid
  input wire logic                         s_arready, // ar ready
  input wire logic [crr_pkg::CRR_DATA_W-1:0] s_rdata,   // read data
  input wire logic                         s_rvalid,  // r valid
  input wire logic                         s_rready,  // r ready
  input wire crr_pkg::crr_cfg_t            cfg        // config out
);
  import crr_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence no_wr_hs;
    !(s_awvalid && s_awready) && !(s_wvalid && s_wready);
  endsequence
  sequence ar_hs;
    s_arvalid && s_arready;
  endsequence
  AST_LEVEL_RST: assert property ($rose(aresetn) |-> !cfg.tx_level_high)
    else $error("probe level not 1 V after reset");
  AST_SHADOW_RST: assert property ($rose(aresetn) |->
      cfg.shadow_seg2 == 4'h5 && cfg.shadow_seg1 == 4'h4)
    else $error("shadow reset value wrong");
  AST_QUIET_RST: assert property ($rose(aresetn) |->
      cfg.post_quiet == 2'h1 && cfg.pre_quiet == 2'h1)
    else $error("quiet reset value wrong");
  AST_TAP_RST: assert property ($rose(aresetn) |->
      cfg.tap_end == 7'h24 && cfg.tap_start == 7'h04)
    else $error("tap window reset value wrong");
  AST_DUR_RST: assert property ($rose(aresetn) |-> cfg.probe_dur_us == 16'h3e80)
    else $error("duration reset value wrong");
  AST_THR_RST: assert property ($rose(aresetn) |->
      cfg.thr_tap_ofs == 7'h05 && cfg.thr_const == 8'h3e && cfg.thr_slope_x16 == 8'h0a)
    else $error("threshold reset value wrong");
  AST_CFG_HOLD: assert property (no_wr_hs [*3] |-> $stable(cfg))
    else $error("config changed without a write");
  AST_UPPER_ZERO: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_R_NEXT: assert property (ar_hs |=> s_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped before taken");
endmodule
bind crr_regs crr_regs_checker i_crr_regs_checker (.aclk, .aresetn, .s_awvalid, .s_awready,
  .s_wvalid, .s_wready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .cfg);
`default_nettype wire

// *** bench/crr_regs_tb.sv ***
/*
  Self-checking bench for the reflectometry register bank.
  Assumes 20 MHz aclk; the bench is AXI4-Lite master and engine.
*/
`timescale 1ns/1ps
`default_nettype none
module crr_regs_tb;
  import crr_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [15:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [3:0]  s_wstrb = '0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, meas_done = 0;
  logic [1:0]  s_bresp, s_rresp;
  crr_peaks_t  meas_peaks = '0;
  crr_cfg_t    cfg;
  int          error_cnt = 0, checks = 0;
  logic [15:0] rst_v [6] = '{16'h0545, 16'h2404, 16'h3e80, 16'h053e, 16'h000a, 16'h0000};
  logic [15:0] msk_v [6] = '{16'h1fff, 16'h7f7f, 16'hffff, 16'h7fff, 16'h00ff, 16'h0000};
  always #25 aclk = ~aclk;
  crr_regs i_crr_regs (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .meas_done, .meas_peaks, .cfg);
  function automatic logic [15:0] addr(int i);
    return 16'h0c00 + 16'(4 * i);
  endfunction
  function automatic logic [15:0] cfg_view(int i);
    case (i)
      0: return {3'h0, cfg.tx_level_high, cfg.shadow_seg2, cfg.shadow_seg1,
                 cfg.post_quiet, cfg.pre_quiet};
      1: return {1'b0, cfg.tap_end, 1'b0, cfg.tap_start};
      2: return cfg.probe_dur_us;
      3: return {1'b0, cfg.thr_tap_ofs, cfg.thr_const};
      default: return {8'h00, cfg.thr_slope_x16};
    endcase
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // a write that never answers leaves r unknown, which the caller's compare counts
  task automatic axi_wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] st,
                        output logic [1:0] r);
    bit aw, w, b;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= {16'h0000, d};
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int n = 0; n < 64 && !b; n++) begin
      @(posedge aclk);
      if (s_awready) aw = 1;
      if (s_wready) w = 1;
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        b = 1;
        r = s_bresp;
        s_bready <= 1'b0;
      end
    end
  endtask
  task automatic rd_cmp(input logic [15:0] a, input logic [15:0] e, input logic [1:0] er);
    bit ar, rd;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int n = 0; n < 64 && !rd; n++) begin
      @(posedge aclk);
      if (s_arready) ar = 1;
      if (ar) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        rd = 1;
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
      end
    end
    cmp(d, {16'h0000, e});
    cmp(32'(r), 32'(er));
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic test_reset;
    for (int i = 0; i < 6; i++) begin
      rd_cmp(addr(i), rst_v[i], CRR_RESP_OKAY);
      if (i < 5) cmp(32'(cfg_view(i)), 32'(rst_v[i]));
    end
    $display("test_reset done");
  endtask
  task automatic test_rw;
    logic [1:0] r;
    logic [15:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 16'h5a5a : 16'hffff;
      for (int i = 0; i < 6; i++) begin
        axi_wr(addr(i), p, 4'hf, r);
        cmp(32'(r), 32'(CRR_RESP_OKAY));
      end
      for (int i = 0; i < 6; i++) begin
        rd_cmp(addr(i), p&msk_v[i], CRR_RESP_OKAY);
        if (i<5) cmp(32'(cfg_view(i)), 32'(p&msk_v[i]));
      end
    end
    $display("test_rw done");
  endtask
  task automatic test_strobe;
    logic [1:0] r;
    axi_wr(addr(2), 16'h1234, 4'b0001, r);
    cmp(32'(r), 32'(CRR_RESP_OKAY));
    rd_cmp(addr(2), 16'h5a34, CRR_RESP_OKAY);
    axi_wr(addr(2), 16'hbeef, 4'b0010, r);
    cmp(32'(r), 32'(CRR_RESP_OKAY));
    rd_cmp(addr(2), 16'hbe34, CRR_RESP_OKAY);
    // upper strobes cover no register bits, so nothing may change
    axi_wr(addr(2), 16'h0000, 4'b1100, r);
    cmp(32'(r), 32'(CRR_RESP_OKAY));
    rd_cmp(addr(2), 16'hbe34, CRR_RESP_OKAY);
    $display("test_strobe done");
  endtask
  task automatic test_unmapped;
    logic [1:0] r;
    axi_wr(16'h0c18, 16'hffff, 4'hf, r);
    cmp(32'(r), 32'(CRR_RESP_DECERR));
    rd_cmp(16'h0c18, 16'h0000, CRR_RESP_DECERR);
    rd_cmp(16'h0bfc, 16'h0000, CRR_RESP_DECERR);
    $display("test_unmapped done");
  endtask
  task automatic test_peaks;
    logic [1:0] r;
    @(posedge aclk);
    meas_peaks <= '{peak1: 7'h5a, peak0: 7'h33};
    meas_done <= 1'b1;
    @(posedge aclk);
    meas_done <= 1'b0;
    meas_peaks <= '{peak1: 7'h7f, peak0: 7'h7f};
    rd_cmp(addr(5), 16'h5a33, CRR_RESP_OKAY);
    // software must not be able to disturb a held result
    axi_wr(addr(5), 16'hffff, 4'hf, r);
    cmp(32'(r), 32'(CRR_RESP_OKAY));
    rd_cmp(addr(5), 16'h5a33, CRR_RESP_OKAY);
    @(posedge aclk);
    meas_done <= 1'b1;
    @(posedge aclk);
    meas_done <= 1'b0;
    rd_cmp(addr(5), 16'h7f7f, CRR_RESP_OKAY);
    $display("test_peaks done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    do_reset;
    test_reset;
    test_rw;
    test_strobe;
    test_unmapped;
    test_peaks;
    do_reset;
    test_reset;
    stop_test;
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
